// ### calib_status_regs.vh
`ifndef CALIB_STATUS_REGS_VH
`define CALIB_STATUS_REGS_VH

// Register indices and their APB byte addresses (four times the index)
`define IDX_COMMAND          8'h00
`define IDX_STATUS_PRIMARY   8'h01
`define IDX_STATUS_SECONDARY 8'h02
`define IDX_HK_CAL_SELECT    8'h1B
`define IDX_OPERATING_STATE  8'h3C
`define ADDR_COMMAND          {`IDX_COMMAND, 2'b00}
`define ADDR_STATUS_PRIMARY   {`IDX_STATUS_PRIMARY, 2'b00}
`define ADDR_STATUS_SECONDARY {`IDX_STATUS_SECONDARY, 2'b00}
`define ADDR_HK_CAL_SELECT    {`IDX_HK_CAL_SELECT, 2'b00}
`define ADDR_OPERATING_STATE  {`IDX_OPERATING_STATE, 2'b00}

// Calibration opcodes
`define OP_CAL_KICKER 8'h07
`define OP_CAL_OSC    8'h08
`define OP_CAL_PLL    8'h09
`define OP_CAL_LNA    8'h0A

// Trim kinds, also bit positions of the pending mask
`define KIND_KICKER 2'h0
`define KIND_OSC    2'h1
`define KIND_PLL    2'h2
`define KIND_LNA    2'h3

// Primary status bit positions
`define S1_SYNTH_UNLOCK 7
`define S1_TX_PLL_FAIL  6
`define S1_RX_PLL_FAIL  5
`define S1_OSC_FAIL     4
`define S1_KICKER_FAIL  3
`define S1_CHECKSUM     2
`define S1_INSTR_READY  1
`define S1_ADC_DONE     0

// Housekeeping select bits and reset value
`define HK_PLL_BIT    2
`define HK_OSC_BIT    1
`define HK_KICKER_BIT 0
`define HK_RESET      8'h00

// Operating state codes
`define STATE_UNDETERMINED 4'hF
`define STATE_STARTUP      4'hB
`define STATE_ROM_COPY     4'hA
`define STATE_CAL_LNA      4'h9
`define STATE_CAL_PLL      4'h8
`define STATE_CAL_OSC      4'h7
`define STATE_CAL_KICKER   4'h6
`define STATE_STORE_READ   4'h5
`define STATE_STORE_WRITE  4'h4

// Trim watchdog: time in microseconds, clock in MHz
`define CLK_MHZ         10
`define TRIM_TIMEOUT_US 10000
`define TRIM_TIMEOUT_CYC (`TRIM_TIMEOUT_US * `CLK_MHZ)

`endif

// ### sticky_flag_bank.v
`timescale 1ns/1ps
module sticky_flag_bank #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Flag events and clear mask
    input  wire [W-1:0] set,
    input  wire [W-1:0] clr,
    // Flag state
    output reg  [W-1:0] q
);

    // Set beats clear so an event in the clearing cycle survives
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= {W{1'b0}};
        else
            q <= set | (q & ~clr);
    end

endmodule

// ### cal_trim_engine.v
`timescale 1ns/1ps
module cal_trim_engine #(
    parameter TIMEOUT_CYC = 100000
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Launch
    input  wire       start,
    input  wire [1:0] kind,
    // Analog trim handshake
    input  wire       trim_ack,
    input  wire       trim_fail_tx,
    input  wire       trim_fail_rx,
    output reg        trim_req,
    output reg  [1:0] trim_kind,
    // Result
    output reg        done,
    output reg  [1:0] fail
);

    localparam CW = $clog2(TIMEOUT_CYC + 1);
    localparam [CW-1:0] LAST = TIMEOUT_CYC - 1;

    reg [CW-1:0] cnt;

    // A stuck trim must not hang busy forever, so a watchdog fails it
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trim_req  <= 1'b0;
            trim_kind <= 2'h0;
            cnt       <= {CW{1'b0}};
            done      <= 1'b0;
            fail      <= 2'h0;
        end
        else if (!trim_req)
        begin
            done <= 1'b0;
            if (start)
            begin
                trim_req  <= 1'b1;
                trim_kind <= kind;
                cnt       <= {CW{1'b0}};
            end
        end
        else if (trim_ack)
        begin
            trim_req <= 1'b0;
            done     <= 1'b1;
            fail     <= {trim_fail_tx, trim_fail_rx};
        end
        else if (cnt == LAST)
        begin
            trim_req <= 1'b0;
            done     <= 1'b1;
            fail     <= 2'h3;
        end
        else
            cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
    end

endmodule

// ### calibration_status_control.v
// Operation
// R1: A calibration opcode written to the command register starts it.
// R2: Opcodes 07 kicker, 08 oscillator, 09 PLL, 0A LNA.
// R3: Host calibrates once after power-on before any mode.
// R4: Housekeeping select bits 2,1,0 enable PLL, oscillator, kicker.
// R5: Host reads primary status after each calibration.
// R6: Reading a status register clears its flags.
// R7: Primary bit 7 flags synthesiser unlock at startup.
// R8: Primary bits 6..3 flag TX PLL, RX PLL, oscillator, kicker fails.
// R9: Primary bit 2 flags a store checksum failure.
// R10: Primary bit 1 shows instructions are accepted.
// R11: Busy, secondary bit 0, holds through calibration.
// R12: Busy holds during store reads and writes.
// R13: Busy holds while a received packet is processed.
// R14: Busy holds until a buffered transmit has gone.
// R15: Busy holds through housekeeping and bursts.
// R16: Secondary bits 3:1 give the event cause.
// R17: Secondary bits 7:4 give the channel.
// R18: Outside the medical band, secondary bit 0 shows clear-channel failure.
// R19: Operating state register reports the activity code.
// R20: A read returns pre-clear flags; later sets show next read.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "calib_status_regs.vh"
module calibration_status_control #(
    parameter TRIM_TIMEOUT = `TRIM_TIMEOUT_CYC
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Analog trim handshake
    output wire        trim_req,
    output wire [1:0]  trim_kind,
    input  wire        trim_ack,
    input  wire        trim_fail_tx,
    input  wire        trim_fail_rx,
    // Failure and completion events, one-cycle pulses
    input  wire        synth_unlock_evt,
    input  wire        checksum_fail_evt,
    input  wire        adc_done_evt,
    // Activity levels from the rest of the radio
    input  wire        hk_start,
    input  wire        burst_active,
    input  wire        rx_packet_active,
    input  wire        tx_buffered_active,
    input  wire        store_reading,
    input  wire        store_writing,
    input  wire        rom_copy_active,
    input  wire        startup_active,
    input  wire [1:0]  radio_mode,
    // Event cause and channel reports
    input  wire        irq_evt,
    input  wire [2:0]  irq_cause,
    input  wire        chan_evt,
    input  wire [3:0]  chan_index,
    input  wire        cca_nonmedical,
    input  wire        cca_clear,
    // Status outputs
    output reg         housekeeping_cycle,
    output reg         busy,
    output reg         instr_ready
);

    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_LAUNCH = 3'b010;
    localparam [2:0] ST_WAIT   = 3'b100;

    reg  [2:0]  state;
    reg  [3:0]  pending;
    reg  [1:0]  cur_kind;
    reg  [7:0]  hk_cal_select;
    reg  [3:0]  state_code;
    reg  [3:0]  clear_channel_index;
    reg  [2:0]  event_cause;
    reg  [3:0]  next_pending;
    reg  [3:0]  next_state_code;
    reg  [7:0]  flag_set;
    reg  [7:0]  flag_clr;
    wire [7:0]  flags;
    wire        cca_fail_flag;
    wire        eng_done;
    wire [1:0]  eng_fail;
    wire        eng_start;
    wire        apb_setup;
    wire        apb_access;
    wire        rd_primary;
    wire        rd_secondary;
    wire        cmd_write;
    wire        next_busy;
    wire [3:0]  new_bits;
    wire        synth_unlock_flag;
    wire        slow_osc_cal_fail;

    // Highest priority pending trim: LNA, PLL, oscillator, kicker
    function [1:0] pick_kind;
        input [3:0] p;
        begin
            if (p[3])
                pick_kind = `KIND_LNA;
            else if (p[2])
                pick_kind = `KIND_PLL;
            else if (p[1])
                pick_kind = `KIND_OSC;
            else
                pick_kind = `KIND_KICKER;
        end
    endfunction

    // One-hot mask of a trim kind
    function [3:0] kind_bit;
        input [1:0] k;
        begin
            kind_bit = 4'h1 << k;
        end
    endfunction

    // Calibration opcode to pending mask; anything else yields none
    function [3:0] decode_opcode;
        input [7:0] op;
        begin
            case (op)
                `OP_CAL_KICKER: decode_opcode = kind_bit(`KIND_KICKER); // R2
                `OP_CAL_OSC:    decode_opcode = kind_bit(`KIND_OSC);    // R2
                `OP_CAL_PLL:    decode_opcode = kind_bit(`KIND_PLL);    // R2
                `OP_CAL_LNA:    decode_opcode = kind_bit(`KIND_LNA);    // R2
                default:        decode_opcode = 4'h0;
            endcase
        end
    endfunction

    // Address decode for the error path; the read path decodes with its own case
    function is_mapped;
        input [9:0] a;
        begin
            is_mapped = (a == `ADDR_COMMAND) || (a == `ADDR_STATUS_PRIMARY) ||
                        (a == `ADDR_STATUS_SECONDARY) || (a == `ADDR_HK_CAL_SELECT) ||
                        (a == `ADDR_OPERATING_STATE);
        end
    endfunction

    // APB phases; the slave never inserts wait states
    assign apb_setup    = psel & ~penable;
    assign apb_access   = psel & penable;
    assign pready       = 1'b1;
    assign pslverr      = apb_access & ~is_mapped(paddr);
    assign rd_primary   = apb_access & ~pwrite & (paddr == `ADDR_STATUS_PRIMARY);
    assign rd_secondary = apb_access & ~pwrite & (paddr == `ADDR_STATUS_SECONDARY);
    // Commands arriving while not ready are dropped, hence the ready flag
    assign cmd_write    = apb_access & pwrite & (paddr == `ADDR_COMMAND) & instr_ready; // R1 R10

    // Housekeeping and host requests merge into the pending mask
    assign new_bits = (cmd_write ? decode_opcode(pwdata[7:0]) : 4'h0) |
                      (hk_start ? {1'b0, hk_cal_select[`HK_PLL_BIT],
                                   hk_cal_select[`HK_OSC_BIT],
                                   hk_cal_select[`HK_KICKER_BIT]} : 4'h0); // R4

    assign eng_start = (state == ST_LAUNCH);

    // Pending bits: a launch clears only the bit it takes
    always @*
    begin
        next_pending = pending | new_bits;
        if (eng_start)
            next_pending = (pending & ~kind_bit(cur_kind)) | new_bits;
    end

    // Sequencer runs pending trims one after another
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state    <= ST_IDLE;
            pending  <= 4'h0;
            cur_kind <= 2'h0;
        end
        else
        begin
            pending <= next_pending;
            case (state)
                ST_IDLE:
                    if (pending != 4'h0)
                    begin
                        cur_kind <= pick_kind(pending); // R1
                        state    <= ST_LAUNCH;
                    end
                ST_LAUNCH:
                    state <= ST_WAIT;
                ST_WAIT:
                    if (eng_done)
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    cal_trim_engine #(
        .TIMEOUT_CYC (TRIM_TIMEOUT)
    ) u_trim (
        .clk          (pclk),
        .rst_n        (presetn),
        .start        (eng_start),
        .kind         (cur_kind),
        .trim_ack     (trim_ack),
        .trim_fail_tx (trim_fail_tx),
        .trim_fail_rx (trim_fail_rx),
        .trim_req     (trim_req),
        .trim_kind    (trim_kind),
        .done         (eng_done),
        .fail         (eng_fail)
    );

    // Housekeeping cycle spans its whole batch of trims
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            housekeeping_cycle <= 1'b0;
        else if (hk_start)
            housekeeping_cycle <= 1'b1;
        else if (state == ST_IDLE && pending == 4'h0)
            housekeeping_cycle <= 1'b0;
    end

    // Busy covers every activity the host must not interrupt
    assign next_busy = (state != ST_IDLE) | (pending != 4'h0) | // R11
                       store_reading | store_writing |          // R12
                       rx_packet_active |                       // R13
                       tx_buffered_active |                     // R14
                       housekeeping_cycle | hk_start | burst_active | // R15
                       startup_active | rom_copy_active;

    // Registered so busy and ready never disagree within a cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy        <= 1'b1;
            instr_ready <= 1'b0;
        end
        else
        begin
            busy        <= next_busy | cmd_write | (new_bits != 4'h0);
            instr_ready <= ~(next_busy | cmd_write | (new_bits != 4'h0)); // R10
        end
    end

    // Sticky flag events; the ready bit is live and never stored
    always @*
    begin
        flag_set = 8'h00;
        flag_set[`S1_SYNTH_UNLOCK] = synth_unlock_evt; // R7
        if (eng_done && state == ST_WAIT)
        begin
            if (cur_kind == `KIND_PLL)
            begin
                flag_set[`S1_TX_PLL_FAIL] = eng_fail[1]; // R8
                flag_set[`S1_RX_PLL_FAIL] = eng_fail[0]; // R8
            end
            if (cur_kind == `KIND_OSC)
                flag_set[`S1_OSC_FAIL] = |eng_fail; // R8
            if (cur_kind == `KIND_KICKER)
                flag_set[`S1_KICKER_FAIL] = |eng_fail; // R8
        end
        flag_set[`S1_CHECKSUM] = checksum_fail_evt; // R9
        flag_set[`S1_ADC_DONE] = adc_done_evt;
        // Only the bits the host actually saw are cleared
        flag_clr = rd_primary ? prdata[7:0] : 8'h00; // R6 R20
        flag_clr[`S1_INSTR_READY] = 1'b0;
    end

    sticky_flag_bank #(
        .W (8)
    ) u_primary_flags (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (flag_set),
        .clr   (flag_clr),
        .q     (flags)
    );

    assign synth_unlock_flag = flags[`S1_SYNTH_UNLOCK];
    assign slow_osc_cal_fail = flags[`S1_OSC_FAIL];

    sticky_flag_bank #(
        .W (1)
    ) u_cca_flag (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (chan_evt & cca_nonmedical & ~cca_clear), // R18
        .clr   (rd_secondary & cca_nonmedical & prdata[0]), // R6 R20
        .q     (cca_fail_flag)
    );

    // Cause and channel fields; a new report wins over the read clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            event_cause         <= 3'h0;
            clear_channel_index <= 4'h0;
        end
        else
        begin
            if (irq_evt)
                event_cause <= irq_cause; // R16
            else if (rd_secondary)
                event_cause <= 3'h0; // R6
            if (chan_evt)
                clear_channel_index <= chan_index; // R17
            else if (rd_secondary)
                clear_channel_index <= 4'h0; // R6
        end
    end

    // Activity code, calibration and store ahead of radio mode
    always @*
    begin
        if (state != ST_IDLE)
        begin
            case (cur_kind)
                `KIND_LNA: next_state_code = `STATE_CAL_LNA;    // R19
                `KIND_PLL: next_state_code = `STATE_CAL_PLL;    // R19
                `KIND_OSC: next_state_code = `STATE_CAL_OSC;    // R19
                default:   next_state_code = `STATE_CAL_KICKER; // R19
            endcase
        end
        else if (store_reading)
            next_state_code = `STATE_STORE_READ; // R19
        else if (store_writing)
            next_state_code = `STATE_STORE_WRITE; // R19
        else if (rom_copy_active)
            next_state_code = `STATE_ROM_COPY; // R19
        else if (startup_active)
            next_state_code = `STATE_STARTUP; // R19
        else
            next_state_code = {2'b00, radio_mode}; // R19
    end

    // Undetermined until the first clock after reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_code <= `STATE_UNDETERMINED;
        else
            state_code <= next_state_code;
    end

    // Housekeeping select register
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hk_cal_select <= `HK_RESET;
        else if (apb_access && pwrite && paddr == `ADDR_HK_CAL_SELECT)
            hk_cal_select <= pwdata[7:0]; // R4
    end

    // Read data is frozen in the setup cycle, so the access edge
    // clears exactly what is returned
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (apb_setup && !pwrite)
        begin
            case (paddr)
                `ADDR_STATUS_PRIMARY:
                    prdata <= {24'h000000, flags[7:2], instr_ready, flags[0]}; // R10 R20
                `ADDR_STATUS_SECONDARY:
                    prdata <= {24'h000000, clear_channel_index, event_cause,
                               cca_nonmedical ? cca_fail_flag : busy}; // R11 R18
                `ADDR_HK_CAL_SELECT:
                    prdata <= {24'h000000, hk_cal_select};
                `ADDR_OPERATING_STATE:
                    prdata <= {28'h0000000, state_code};
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// ### calib_status_properties.sv
`timescale 1ns/1ps
module calib_status_properties (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [9:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    // Trim handshake and activity
    input wire        trim_req,
    input wire [1:0]  trim_kind,
    input wire        trim_ack,
    input wire        store_reading,
    input wire        store_writing,
    input wire        rx_packet_active,
    input wire        tx_buffered_active,
    input wire        burst_active,
    // Status
    input wire        housekeeping_cycle,
    input wire        busy,
    input wire        instr_ready
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // PLL command write at the access edge, whether or not instr_ready accepts it
    wire pll_cmd = psel && penable && pwrite && paddr == 10'h000 && pwdata[7:0] == 8'h09;

    AST_CMD_PLL: assert property (pll_cmd && instr_ready |-> ##[2:3] (trim_req && trim_kind == 2'h2))
        else $error("no PLL trim");
    AST_CMD_BUSY: assert property (pll_cmd && instr_ready |-> ##2 busy [*3])
        else $error("no busy after command");
    AST_READY_COMP: assert property (busy != instr_ready)
        else $error("busy equals ready");
    AST_TRIM_BUSY: assert property (trim_req |-> busy)
        else $error("trim without busy");
    AST_ACK_DROP: assert property (trim_req && trim_ack |=> !trim_req)
        else $error("trim request held");
    AST_STORE_BUSY: assert property (store_reading || store_writing |=> busy)
        else $error("store access without busy");
    AST_RX_BUSY: assert property (rx_packet_active |=> busy)
        else $error("packet without busy");
    AST_TX_BUSY: assert property (tx_buffered_active |=> busy)
        else $error("transmit without busy");
    AST_BURST_BUSY: assert property (burst_active |=> busy)
        else $error("burst without busy");
    AST_HK_BUSY: assert property (housekeeping_cycle && $past(housekeeping_cycle) |-> busy)
        else $error("housekeeping without busy");

    // Main scenarios reached
    cover property ($rose(trim_req));
    cover property ($rose(housekeeping_cycle));
    cover property (pslverr);
endmodule

bind calibration_status_control calib_status_properties chk_u (.*);

// ### trim_responder.sv
`timescale 1ns/1ps
module trim_responder (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // Trim handshake
    input wire       trim_req,
    input wire [1:0] trim_kind,
    output reg       trim_ack,
    output reg       trim_fail_tx,
    output reg       trim_fail_rx,
    // Scenario controls
    input wire [7:0] ack_delay,
    input wire       bad_tx,
    input wire       bad_rx,
    // Observation
    output reg [7:0] trims_seen,
    output reg [1:0] last_kind
);
    reg [7:0] wait_cnt;
    reg       answered;

    // One answer per request; fail lines toggle between answers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {trim_ack, trim_fail_tx, trim_fail_rx, answered} <= 4'h0;
            wait_cnt <= 8'h00;
            trims_seen <= 8'h00;
            last_kind <= 2'h0;
        end
        else
        begin
            trim_ack <= 1'b0;
            trim_fail_tx <= ~trim_fail_tx;
            trim_fail_rx <= trim_fail_tx;
            if (!trim_req)
            begin
                answered <= 1'b0;
                wait_cnt <= 8'h00;
            end
            else if (!answered && wait_cnt >= ack_delay)
            begin
                trim_ack <= 1'b1;
                trim_fail_tx <= bad_tx;
                trim_fail_rx <= bad_rx;
                answered <= 1'b1;
                trims_seen <= trims_seen + 8'h01;
                last_kind <= trim_kind;
            end
            else if (!answered)
                wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule

// ### test_calibration_status_control.sv
`timescale 1ns/1ps
`include "calib_status_regs.vh"
module test_calibration_status_control;
    // Bench stimulus
    reg        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [9:0]  paddr = 10'h000;
    reg [31:0] pwdata = 32'h0;
    reg        synth_unlock_evt = 1'b0, checksum_fail_evt = 1'b0, adc_done_evt = 1'b0;
    reg        hk_start = 1'b0, irq_evt = 1'b0, chan_evt = 1'b0;
    reg        cca_nonmedical = 1'b0, cca_clear = 1'b0, bad_tx = 1'b0, bad_rx = 1'b0;
    reg [1:0]  radio_mode = 2'h3;
    reg [2:0]  irq_cause = 3'h0;
    reg [3:0]  chan_index = 4'h0;
    reg [6:0]  act = 7'h00;
    // Observed
    wire [31:0] prdata;
    wire [7:0]  seen;
    wire [1:0]  trim_kind, lk;
    wire        pready, pslverr, trim_req, trim_ack, trim_fail_tx, trim_fail_rx;
    wire        housekeeping_cycle, busy, instr_ready;
    wire        burst_active = act[0], rx_packet_active = act[1], tx_buffered_active = act[2];
    wire        store_reading = act[3], store_writing = act[4];
    wire        rom_copy_active = act[5], startup_active = act[6];
    integer     n_mismatch = 0, cmp_count = 0, cyc = 0, i;
    reg [7:0]   rd, base;
    reg         er;

    // Short trim watchdog
    calibration_status_control #(.TRIM_TIMEOUT(20)) dut_u (.*);
    trim_responder far_u (.*, .ack_delay(8'h06), .trims_seen(seen), .last_kind(lk));

    // Clock and hang guard
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end

    task complete_run;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    task chk(input string name, input [7:0] exp, input [7:0] got);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    end
    endtask

    // One APB transfer
    task apb(input w, input [9:0] a, input [7:0] d);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task rchk(input [9:0] a, input [7:0] exp, input string name);
    begin
        apb(1'b0, a, 8'h00);
        chk(name, exp, rd);
    end
    endtask

    task wait_idle;
    begin
        repeat (2) @(posedge pclk);
        while (busy !== 1'b0)
            @(posedge pclk);
    end
    endtask

    task pulse(input [2:0] c, input [3:0] ch, input clr);
    begin
        @(posedge pclk);
        {irq_evt, chan_evt, irq_cause, chan_index, cca_clear} <= {2'b11, c, ch, clr};
        @(posedge pclk);
        {irq_evt, chan_evt} <= 2'b00;
    end
    endtask

    // One calibration with checks
    task cal(input [7:0] op, input tx, input rx, input [7:0] exp1);
    begin
        bad_tx <= tx;
        bad_rx <= rx;
        while (instr_ready !== 1'b1)
            @(posedge pclk);
        apb(1'b1, `ADDR_COMMAND, op);
        @(posedge pclk);
        rchk(`ADDR_OPERATING_STATE, op - 8'h01, "cal state");
        wait_idle;
        chk("trim kind", op - 8'h07, {6'h00, lk});
        rchk(`ADDR_STATUS_PRIMARY, exp1, "status1 after cal");
    end
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`ADDR_HK_CAL_SELECT, `HK_RESET, "hk reset");
        rchk(`ADDR_OPERATING_STATE, 8'h03, "idle state");
        rchk(`ADDR_COMMAND, 8'h00, "command read");
        rchk(10'h3FC, 8'h00, "unmapped read");
        chk("unmapped err", 8'h01, {7'h00, er});
        $display("reset done");

        cal(`OP_CAL_KICKER, 1'b0, 1'b1, 8'h0A);
        cal(`OP_CAL_OSC, 1'b1, 1'b0, 8'h12);
        cal(`OP_CAL_PLL, 1'b1, 1'b0, 8'h42);
        cal(`OP_CAL_PLL, 1'b0, 1'b1, 8'h22);
        cal(`OP_CAL_LNA, 1'b1, 1'b1, 8'h02);
        cal(`OP_CAL_PLL, 1'b0, 1'b0, 8'h02);
        rchk(`ADDR_STATUS_PRIMARY, 8'h02, "status1 cleared");
        $display("cal done");

        @(posedge pclk);
        {synth_unlock_evt, checksum_fail_evt, adc_done_evt} <= 3'b111;
        @(posedge pclk);
        {synth_unlock_evt, checksum_fail_evt, adc_done_evt} <= 3'b000;
        rchk(`ADDR_STATUS_PRIMARY, 8'h87, "status1 events");
        rchk(`ADDR_STATUS_PRIMARY, 8'h02, "status1 after read");
        fork
            rchk(`ADDR_STATUS_PRIMARY, 8'h02, "status1 pre-clear");
            begin
                repeat (2) @(posedge pclk);
                checksum_fail_evt <= 1'b1;
                @(posedge pclk);
                checksum_fail_evt <= 1'b0;
            end
        join
        rchk(`ADDR_STATUS_PRIMARY, 8'h06, "status1 late set");
        $display("status1 done");

        for (i = 0; i < 8; i = i + 1)
        begin
            pulse(i, 15 - i, 1'b0);
            rchk(`ADDR_STATUS_SECONDARY, {4'(15 - i), 3'(i), 1'b0}, "status2 cause");
        end
        rchk(`ADDR_STATUS_SECONDARY, 8'h00, "status2 cleared");
        cca_nonmedical <= 1'b1;
        pulse(3'h0, 4'h5, 1'b0);
        rchk(`ADDR_STATUS_SECONDARY, 8'h51, "cca failed");
        rchk(`ADDR_STATUS_SECONDARY, 8'h00, "cca cleared");
        pulse(3'h0, 4'h3, 1'b1);
        rchk(`ADDR_STATUS_SECONDARY, 8'h30, "cca clear");
        cca_nonmedical <= 1'b0;
        $display("status2 done");

        for (i = 0; i < 3; i = i + 1)
        begin
            apb(1'b1, `ADDR_HK_CAL_SELECT, 8'h07 >> (2 * i));
            rchk(`ADDR_HK_CAL_SELECT, 8'h07 >> (2 * i), "hk select");
            base = seen;
            @(posedge pclk);
            hk_start <= 1'b1;
            @(posedge pclk);
            hk_start <= 1'b0;
            repeat (2) @(posedge pclk);
            chk("hk level", {7'h00, i < 2}, {7'h00, housekeeping_cycle});
            wait_idle;
            chk("hk trims", 8'h03 >> i, seen - base);
            if (i < 2)
                chk("hk last kind", 8'h00, {6'h00, lk});
        end
        $display("hk done");

        for (i = 0; i < 7; i = i + 1)
        begin
            act <= 7'h01 << i;
            base = seen;
            repeat (2) @(posedge pclk);
            chk("busy level", 8'h01, {7'h00, busy});
            apb(1'b1, `ADDR_COMMAND, `OP_CAL_PLL);
            if (i > 2)
                rchk(`ADDR_OPERATING_STATE, (i > 4) ? i + 5 : 8 - i, "activity state");
            act <= 7'h00;
            wait_idle;
            chk("refused cmd", base, seen);
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            radio_mode <= i;
            rchk(`ADDR_OPERATING_STATE, i, "mode state");
        end
        $display("busy done");
        complete_run;
    end
endmodule
